/* File: rtl/cmo_core_mem.sv */
// Core memory organisation: return stack, program counter vectors, banked
// data address decode, core registers, indirect pointers and flag masking.
// Assumes the execution pipeline drives one-cycle strobes on clk and that
// data RAM, peripheral registers and program flash sit outside.
`timescale 1ns/100ps
// Behaviour
// - Return stack: sixteen entries, fifteen bits each.
// - Over/underflow sets flag; optional software reset.
// - Two 16-bit pointers cover data and program.
// - Program-space indirect read adds one cycle.
// - Program counter fifteen bits wide.
// - Program addresses wrap into 4096 words.
// - Reset fetches 0000h; interrupt vectors 0004h.
// - High endurance only low byte, 0F80h-0FFFh.
// - Pointer high bit 7 selects program memory.
// - Indirect load takes program word's low byte.
// - Indirect writes never change program memory.
// - Thirty-two banks of 128 bytes.
// - Bank: core, special, general, common areas.
// - Direct access uses last written bank select.
// - Unimplemented data locations read as zero.
// - Twelve-bit address: five bank, seven offset.
// - Core registers mirrored at offsets 00h-0Bh.
// - Flag destination writes, except clears, lose to computed flags.
// - Watchdog and sleep flags ignore writes.
// - Clearing flags register zeroes top, sets zero.
// - Carry flags are active-low borrows on subtract.
// - Shadow copies on interrupt, restored on return.
// - Nibble carry from fourth low result bit.
// - Carry from the most significant result bit.
module cmo_core_mem (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        stack_reset_en,
    input  wire logic        call_push,
    input  wire logic        ret_pop,
    input  wire logic        irq_entry,
    input  wire logic        irq_return,
    input  wire logic        pc_load,
    input  wire logic [14:0] pc_load_value,
    input  wire logic        pc_step,
    input  wire logic        wdt_timeout,
    input  wire logic        sleep_exec,
    input  wire logic        wdt_clear,
    input  wire logic        file_rd,
    input  wire logic        file_wr,
    input  wire logic        file_indirect,
    input  wire logic        file_ptr_sel,
    input  wire logic [6:0]  file_offset,
    input  wire logic [7:0]  file_wdata,
    input  wire logic        file_clear,
    input  wire logic        alu_flags_valid,
    input  wire logic        alu_is_sub,
    input  wire logic        alu_sets_carry,
    input  wire logic [7:0]  alu_a,
    input  wire logic [7:0]  alu_b,
    input  wire logic [7:0]  ext_rdata,
    input  wire logic [13:0] pfm_rdata,
    input  wire logic        pfm_rvalid,
    output logic [14:0]      pc_out,
    output logic [14:0]      pfm_addr,
    output logic             pfm_rd,
    output logic             pfm_high_endurance,
    output logic [11:0]      data_addr,
    output logic             data_rd,
    output logic             data_wr,
    output logic [7:0]       data_wdata,
    output logic [7:0]       file_rdata,
    output logic             file_rdata_valid,
    output logic             stall,
    output logic             stack_overflow_flag,
    output logic             stack_underflow_flag,
    output logic             soft_reset,
    output logic [7:0]       arith_flags,
    output logic [7:0]       accumulator,
    output logic [4:0]       bank_select
);
    typedef enum logic [1:0] {
        CMO_IDLE  = 2'b00,
        CMO_FETCH = 2'b01
    } cmo_ind_t;

    logic [1:0]  rst_sync_q;
    logic        rst_i_n;
    logic [14:0] stack_q [cmo_pkg::STACK_DEPTH];
    logic [4:0]  sp_q;
    logic [14:0] pc_q;
    logic [7:0]  program_counter_high_latch_q, interrupt_control_q;
    logic [15:0] ptr_q [2];
    logic [7:0]  flags_sh_q, acc_sh_q, bsel_sh_q, program_counter_high_latch_sh_q;
    logic [15:0] ptr_sh_q [2];
    cmo_ind_t    ind_q;
    logic        push_full, pop_empty;
    logic [8:0]  sum9;
    logic [4:0]  sum5;
    logic [15:0] cur_ptr;
    logic        ind_pfm;
    logic        core_hit;
    logic [11:0] dir_addr;

    // Reset releases through two flops so the core leaves reset on a clean edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_i_n = rst_sync_q[1];

    // Decode that both the read path and the write path need.
    function automatic logic is_core(input logic [6:0] ofs);
        is_core = (ofs <= cmo_pkg::OFS_INTC);
    endfunction : is_core

    // Interrupt entry and return move the stack as well, so they can trip the flags too.
    assign push_full = (call_push || irq_entry) && (sp_q == 5'(cmo_pkg::STACK_DEPTH));
    assign pop_empty = (ret_pop || irq_return) && (sp_q == 5'h00);
    assign cur_ptr   = ptr_q[file_ptr_sel];
    assign ind_pfm   = cur_ptr[8 + cmo_pkg::PTR_PFM_BIT];
    assign core_hit  = is_core(file_offset);
    assign dir_addr  = {bank_select, file_offset};

    // Return stack; the return address is the fetch address of the next word.
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            sp_q <= 5'h00;
        end else if ((call_push || irq_entry) && !push_full
                     && sp_q != 5'(cmo_pkg::STACK_DEPTH)) begin
            stack_q[sp_q[3:0]] <= pc_q;
            sp_q <= sp_q + 5'h01;
        end else if ((ret_pop || irq_return) && sp_q != 5'h00) begin
            sp_q <= sp_q - 5'h01;
        end
    end

    // Flags are sticky until reset; overflow/underflow may also force reset.
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            stack_overflow_flag  <= 1'b0;
            stack_underflow_flag <= 1'b0;
            soft_reset           <= 1'b0;
        end else begin
            if (push_full) stack_overflow_flag <= 1'b1;
            if (pop_empty) stack_underflow_flag <= 1'b1;
            soft_reset <= stack_reset_en && (push_full || pop_empty);
        end
    end

    // Program counter with wrap into the implemented 4K words.
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            pc_q <= cmo_pkg::RESET_VECTOR;
        end else if (irq_entry) begin
            pc_q <= cmo_pkg::IRQ_VECTOR;
        end else if ((ret_pop || irq_return) && sp_q != 5'h00) begin
            pc_q <= stack_q[sp_q[3:0] - 4'h1] & cmo_pkg::PFM_MASK;
        end else if (pc_load) begin
            pc_q <= pc_load_value & cmo_pkg::PFM_MASK;
        end else if (pc_step && !stall) begin
            pc_q <= (pc_q + 15'h0001) & cmo_pkg::PFM_MASK;
        end
    end
    assign pc_out = pc_q;

    // Indirect program reads take one extra cycle for the flash fetch.
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            ind_q <= CMO_IDLE;
        end else begin
            unique case (ind_q)
                CMO_IDLE:  if (file_rd && file_indirect && ind_pfm) ind_q <= CMO_FETCH;
                CMO_FETCH: ind_q <= CMO_IDLE;
            endcase
        end
    end

    // Flash address strobe and endurance marker, registered like all outputs.
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            pfm_addr           <= 15'h0000;
            pfm_rd             <= 1'b0;
            pfm_high_endurance <= 1'b0;
            stall              <= 1'b0;
        end else begin
            pfm_rd <= ind_q == CMO_IDLE && file_rd && file_indirect && ind_pfm;
            stall  <= ind_q == CMO_IDLE && file_rd && file_indirect && ind_pfm;
            pfm_addr <= cur_ptr[14:0] & cmo_pkg::PFM_MASK;
            // Only the low byte of these words is rated for heavy rewriting.
            pfm_high_endurance <= (cur_ptr[14:0] & cmo_pkg::PFM_MASK) >= cmo_pkg::HE_FIRST
                                  && (cur_ptr[14:0] & cmo_pkg::PFM_MASK) <= cmo_pkg::HE_LAST;
        end
    end

    // Data-side strobes; core offsets never leave the block.
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            data_addr  <= 12'h000;
            data_rd    <= 1'b0;
            data_wr    <= 1'b0;
            data_wdata <= 8'h00;
        end else begin
            data_addr  <= file_indirect ? cur_ptr[11:0] : dir_addr;
            data_rd    <= file_rd && !(file_indirect ? (ind_pfm || is_core(cur_ptr[6:0]))
                                                     : core_hit);
            // Program-space targets drop the write entirely.
            data_wr    <= file_wr && !(file_indirect ? (ind_pfm || is_core(cur_ptr[6:0]))
                                                     : core_hit);
            data_wdata <= file_clear ? 8'h00 : file_wdata;
        end
    end

    // Read return; external data outside core registers, flash low byte.
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            file_rdata       <= 8'h00;
            file_rdata_valid <= 1'b0;
        end else begin
            file_rdata_valid <= (ind_q == CMO_FETCH && pfm_rvalid)
                                || (file_rd && !(file_indirect && ind_pfm));
            if (ind_q == CMO_FETCH) begin
                file_rdata <= pfm_rdata[7:0];
            end else if (file_rd && core_hit && !file_indirect) begin
                unique case (file_offset)
                    cmo_pkg::OFS_PCL:   file_rdata <= pc_q[7:0];
                    cmo_pkg::OFS_FLAGS: file_rdata <= arith_flags;
                    cmo_pkg::OFS_P0L:   file_rdata <= ptr_q[0][7:0];
                    cmo_pkg::OFS_P0H:   file_rdata <= ptr_q[0][15:8];
                    cmo_pkg::OFS_P1L:   file_rdata <= ptr_q[1][7:0];
                    cmo_pkg::OFS_P1H:   file_rdata <= ptr_q[1][15:8];
                    cmo_pkg::OFS_BSEL:  file_rdata <= {3'h0, bank_select};
                    cmo_pkg::OFS_ACC:   file_rdata <= accumulator;
                    cmo_pkg::OFS_PCLH:  file_rdata <= program_counter_high_latch_q;
                    cmo_pkg::OFS_INTC:  file_rdata <= interrupt_control_q;
                    default:            file_rdata <= 8'h00;
                endcase
            end else if (file_rd) begin
                file_rdata <= ext_rdata;    // Outside logic returns zero for holes.
            end
        end
    end

    // Adder for flag computation; subtraction adds the two's complement.
    assign sum9 = {1'b0, alu_a} + (alu_is_sub ? {1'b0, ~alu_b} + 9'h001
                                              : {1'b0, alu_b});
    assign sum5 = {1'b0, alu_a[3:0]} + (alu_is_sub ? {1'b0, ~alu_b[3:0]} + 5'h01
                                                   : {1'b0, alu_b[3:0]});

    // Arithmetic flags; computed values beat data writes but lose to a clear, TO/PD are read-only.
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            arith_flags <= cmo_pkg::FLAGS_RESET;
        end else begin
            if (irq_return) begin
                arith_flags <= flags_sh_q;
            end else if (file_wr && !file_indirect && file_offset == cmo_pkg::OFS_FLAGS) begin
                if (file_clear) begin
                    arith_flags[7:5] <= 3'h0;
                    arith_flags[cmo_pkg::F_Z] <= 1'b1;
                end else if (!alu_flags_valid) begin
                    arith_flags[cmo_pkg::F_C]  <= file_wdata[cmo_pkg::F_C];
                    arith_flags[cmo_pkg::F_DC] <= file_wdata[cmo_pkg::F_DC];
                    arith_flags[cmo_pkg::F_Z]  <= file_wdata[cmo_pkg::F_Z];
                end
            end
            if (alu_flags_valid && !irq_return && !file_clear) begin
                arith_flags[cmo_pkg::F_Z] <= sum9[7:0] == 8'h00;
                if (alu_sets_carry) begin
                    arith_flags[cmo_pkg::F_DC] <= sum5[4];
                    arith_flags[cmo_pkg::F_C]  <= sum9[8];
                end
            end
            // Status events from the watchdog and sleep logic only.
            if (wdt_clear) begin
                arith_flags[cmo_pkg::F_TO] <= 1'b1;
                arith_flags[cmo_pkg::F_PD] <= 1'b1;
            end else if (wdt_timeout) begin
                arith_flags[cmo_pkg::F_TO] <= 1'b0;
            end else if (sleep_exec) begin
                arith_flags[cmo_pkg::F_PD] <= 1'b0;
            end
        end
    end

    // Core register writes through direct access at mirrored offsets.
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            accumulator <= cmo_pkg::BYTE_RESET;
            bank_select <= 5'h00;
            program_counter_high_latch_q    <= cmo_pkg::BYTE_RESET;
            interrupt_control_q    <= cmo_pkg::BYTE_RESET;
            ptr_q[0]    <= 16'h0000;
            ptr_q[1]    <= 16'h0000;
        end else if (irq_return) begin
            accumulator <= acc_sh_q;
            bank_select <= bsel_sh_q[4:0];
            program_counter_high_latch_q    <= program_counter_high_latch_sh_q;
            ptr_q[0]    <= ptr_sh_q[0];
            ptr_q[1]    <= ptr_sh_q[1];
        end else if (file_wr && !file_indirect && core_hit) begin
            unique case (file_offset)
                cmo_pkg::OFS_P0L:  ptr_q[0][7:0]  <= file_clear ? 8'h00 : file_wdata;
                cmo_pkg::OFS_P0H:  ptr_q[0][15:8] <= file_clear ? 8'h00 : file_wdata;
                cmo_pkg::OFS_P1L:  ptr_q[1][7:0]  <= file_clear ? 8'h00 : file_wdata;
                cmo_pkg::OFS_P1H:  ptr_q[1][15:8] <= file_clear ? 8'h00 : file_wdata;
                cmo_pkg::OFS_BSEL: bank_select    <= file_clear ? 5'h00 : file_wdata[4:0];
                cmo_pkg::OFS_ACC:  accumulator    <= file_clear ? 8'h00 : file_wdata;
                cmo_pkg::OFS_PCLH: program_counter_high_latch_q       <= file_clear ? 8'h00 : file_wdata;
                cmo_pkg::OFS_INTC: interrupt_control_q       <= file_clear ? 8'h00 : file_wdata;
                default: ;
            endcase
        end else if (ind_q == CMO_FETCH && pfm_rvalid) begin
            accumulator <= pfm_rdata[7:0];
        end
    end

    // Shadow copies taken on interrupt entry.
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            flags_sh_q  <= cmo_pkg::FLAGS_RESET;
            acc_sh_q    <= cmo_pkg::BYTE_RESET;
            bsel_sh_q   <= cmo_pkg::BYTE_RESET;
            program_counter_high_latch_sh_q <= cmo_pkg::BYTE_RESET;
            ptr_sh_q[0] <= 16'h0000;
            ptr_sh_q[1] <= 16'h0000;
        end else if (irq_entry) begin
            flags_sh_q  <= arith_flags;
            acc_sh_q    <= accumulator;
            bsel_sh_q   <= {3'h0, bank_select};
            program_counter_high_latch_sh_q <= program_counter_high_latch_q;
            ptr_sh_q[0] <= ptr_q[0];
            ptr_sh_q[1] <= ptr_q[1];
        end
    end

    chk_ovf_sets : assert property (@(posedge clk) disable iff (!rst_i_n)
        push_full |=> stack_overflow_flag) else $error("overflow flag not set");
    chk_unf_sets : assert property (@(posedge clk) disable iff (!rst_i_n)
        pop_empty |=> stack_underflow_flag) else $error("underflow flag not set");
    chk_sreset_gate : assert property (@(posedge clk) disable iff (!rst_i_n)
        soft_reset |-> $past(stack_reset_en)) else $error("soft reset without enable");
    chk_sp_bound : assert property (@(posedge clk) disable iff (!rst_i_n)
        sp_q <= 5'd16) else $error("stack pointer past depth");
    chk_irq_vector : assert property (@(posedge clk) disable iff (!rst_i_n)
        irq_entry |=> pc_q == cmo_pkg::IRQ_VECTOR) else $error("bad interrupt vector");
    chk_pc_wrap : assert property (@(posedge clk) disable iff (!rst_i_n)
        pc_q[14:12] == 3'h0) else $error("program counter outside 4K");
    chk_ind_stall : assert property (@(posedge clk) disable iff (!rst_i_n)
        (ind_q == CMO_IDLE && file_rd && file_indirect && ind_pfm) |=> stall ##1 !stall)
        else $error("program read stall not one cycle");
    chk_pfm_nowr : assert property (@(posedge clk) disable iff (!rst_i_n)
        (file_wr && file_indirect && ind_pfm) |=> !data_wr) else $error("write hit program");
    chk_to_ro : assert property (@(posedge clk) disable iff (!rst_i_n)
        (!wdt_clear && !wdt_timeout && !irq_return) |=> $stable(arith_flags[cmo_pkg::F_TO]))
        else $error("watchdog flag written");
    chk_bank_wr : assert property (@(posedge clk) disable iff (!rst_i_n)
        (file_wr && !file_indirect && file_offset == cmo_pkg::OFS_BSEL && !file_clear
         && !irq_return) |=> bank_select == $past(file_wdata[4:0]))
        else $error("bank select not written");
    // A cleared flags register must still show the zero flag, whatever was written.
    chk_clear_flags : assert property (@(posedge clk) disable iff (!rst_i_n)
        (file_wr && !file_indirect && file_offset == cmo_pkg::OFS_FLAGS && file_clear
         && !irq_return) |=> arith_flags[7:5] == 3'h0 && arith_flags[cmo_pkg::F_Z])
        else $error("clear of flags register wrong");
    chk_pfm_byte : assert property (@(posedge clk) disable iff (!rst_i_n)
        (ind_q == CMO_FETCH && pfm_rvalid) |=> file_rdata == $past(pfm_rdata[7:0]))
        else $error("program byte not returned");
    cov_overflow : cover property (@(posedge clk) disable iff (!rst_i_n) push_full);
    cov_underflow : cover property (@(posedge clk) disable iff (!rst_i_n) pop_empty);
    cov_pfm_read : cover property (@(posedge clk) disable iff (!rst_i_n) ind_q == CMO_FETCH);
    cov_irq_round : cover property (@(posedge clk) disable iff (!rst_i_n)
        irq_entry ##[1:20] irq_return);
endmodule : cmo_core_mem

/* File: shared/cmo_pkg.sv */
// Package for the core memory organisation block: core register offsets,
// flag positions, address widths, stack depth and vector addresses.
// Assumes a single core clock; every user writes cmo_pkg::name in full.
package cmo_pkg;
    localparam int unsigned PC_W        = 15;
    localparam int unsigned STACK_DEPTH = 16;
    localparam int unsigned SP_W        = 5;
    localparam int unsigned PWORD_W     = 14;
    localparam int unsigned DADDR_W     = 12;
    localparam int unsigned BANK_W      = 5;
    localparam int unsigned OFS_W       = 7;
    localparam int unsigned BANKS       = 32;

    localparam logic [PC_W-1:0] RESET_VECTOR = 15'h0000;
    localparam logic [PC_W-1:0] IRQ_VECTOR   = 15'h0004;
    localparam logic [PC_W-1:0] PFM_MASK     = 15'h0fff;
    localparam logic [PC_W-1:0] HE_FIRST     = 15'h0f80;
    localparam logic [PC_W-1:0] HE_LAST      = 15'h0fff;

    // Core register offsets and special, general and common area starts inside every bank.
    localparam logic [OFS_W-1:0] OFS_IND0  = 7'h00;
    localparam logic [OFS_W-1:0] OFS_IND1  = 7'h01;
    localparam logic [OFS_W-1:0] OFS_PCL   = 7'h02;
    localparam logic [OFS_W-1:0] OFS_FLAGS = 7'h03;
    localparam logic [OFS_W-1:0] OFS_P0L   = 7'h04;
    localparam logic [OFS_W-1:0] OFS_P0H   = 7'h05;
    localparam logic [OFS_W-1:0] OFS_P1L   = 7'h06;
    localparam logic [OFS_W-1:0] OFS_P1H   = 7'h07;
    localparam logic [OFS_W-1:0] OFS_BSEL  = 7'h08;
    localparam logic [OFS_W-1:0] OFS_ACC   = 7'h09;
    localparam logic [OFS_W-1:0] OFS_PCLH  = 7'h0a;
    localparam logic [OFS_W-1:0] OFS_INTC  = 7'h0b;
    localparam logic [OFS_W-1:0] OFS_SFR   = 7'h0c;
    localparam logic [OFS_W-1:0] OFS_GPR   = 7'h20;
    localparam logic [OFS_W-1:0] OFS_COMMON = 7'h70;

    // Flag positions of the arithmetic flags register, and the pointer high-byte bit that selects program memory.
    localparam int unsigned F_C  = 0;
    localparam int unsigned F_DC = 1;
    localparam int unsigned F_Z  = 2;
    localparam int unsigned F_PD = 3;
    localparam int unsigned F_TO = 4;
    localparam int unsigned PTR_PFM_BIT = 7;

    localparam logic [7:0] FLAGS_RESET = 8'h18;
    localparam logic [7:0] BYTE_RESET  = 8'h00;
endpackage : cmo_pkg

/* File: sim/cmo_core_mem_tb.sv */
// Self-checking bench for the core memory organisation block.
// Assumes the block carries its own assertions and that the bench stands in for the pipeline.
`timescale 1ns/100ps
module cmo_core_mem_tb;
    logic        clk = 1'b0, rst_n = 1'b0, stack_reset_en = 1'b1;
    logic        call_push = 1'b0, ret_pop = 1'b0, irq_entry = 1'b0, irq_return = 1'b0;
    logic        pc_load = 1'b0, pc_step = 1'b0, wdt_timeout = 1'b0, sleep_exec = 1'b0;
    logic        wdt_clear = 1'b0, file_rd = 1'b0, file_wr = 1'b0, file_indirect = 1'b0;
    logic        file_ptr_sel = 1'b0, file_clear = 1'b0, pfm_rvalid = 1'b0;
    logic        alu_flags_valid = 1'b0, alu_is_sub = 1'b0, alu_sets_carry = 1'b1;
    logic [14:0] pc_load_value = 15'h0000;
    logic [6:0]  file_offset = 7'h00;
    logic [7:0]  file_wdata = 8'h00, alu_a = 8'h00, alu_b = 8'h00, ext_rdata = 8'h00;
    logic [13:0] pfm_rdata = 14'h0000;
    logic [14:0] pc_out, pfm_addr;
    logic        pfm_rd, pfm_high_endurance, data_rd, data_wr, file_rdata_valid, stall;
    logic        stack_overflow_flag, stack_underflow_flag, soft_reset;
    logic [11:0] data_addr;
    logic [7:0]  data_wdata, file_rdata, arith_flags, accumulator;
    logic [4:0]  bank_select;
    int          bad_count = 0, check_count = 0, cycles = 0;

    cmo_core_mem i_cmo_core_mem (.clk, .rst_n, .stack_reset_en, .call_push, .ret_pop,
        .irq_entry, .irq_return, .pc_load, .pc_load_value, .pc_step, .wdt_timeout,
        .sleep_exec, .wdt_clear, .file_rd, .file_wr, .file_indirect, .file_ptr_sel,
        .file_offset, .file_wdata, .file_clear, .alu_flags_valid, .alu_is_sub,
        .alu_sets_carry, .alu_a, .alu_b, .ext_rdata, .pfm_rdata, .pfm_rvalid, .pc_out,
        .pfm_addr, .pfm_rd, .pfm_high_endurance, .data_addr, .data_rd, .data_wr,
        .data_wdata, .file_rdata, .file_rdata_valid, .stall, .stack_overflow_flag,
        .stack_underflow_flag, .soft_reset, .arith_flags, .accumulator, .bank_select);

    // The core clock toggles every half period of 2 ns.
    always #2 clk = ~clk;

    // A hang would leave the run waiting forever, so cycles are capped well above need.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Six control strobes as one vector, so one statement sets or clears them all.
    task automatic ev(input logic [5:0] v);
        {call_push, ret_pop, irq_entry, pc_load, pc_step, wdt_timeout} = v;
    endtask : ev

    task automatic do_reset();
        rst_n = 1'b0;
        step(2);
        rst_n = 1'b1;
        step(3);
    endtask : do_reset

    // One file access taken at the next edge; it is left standing so that
    // back-to-back accesses never assign a strobe twice in one time step.
    task automatic acc(input logic wr, input logic ind, input logic sel,
                       input logic [6:0] ofs, input logic [7:0] d);
        {file_wr, file_rd, file_indirect, file_ptr_sel} = {wr, ~wr, ind, sel};
        {file_offset, file_wdata} = {ofs, d};
        step(1);
    endtask : acc

    task automatic idle();
        {file_wr, file_rd, file_indirect, file_clear} = 4'h0;
    endtask : idle

    task automatic alu(input logic sub, input logic [7:0] a, input logic [7:0] b);
        {alu_flags_valid, alu_is_sub, alu_a, alu_b} = {1'b1, sub, a, b};
    endtask : alu

    initial begin
        do_reset();
        chk("pc_out", 16'(pc_out), 16'h0000);
        chk("arith_flags", 16'(arith_flags), 16'h0018);
        ev(6'h04);
        pc_load_value = 15'h7ffe;
        step(1);
        ev(6'h02);
        step(1);
        ev(6'h08);
        step(1);
        chk("pc_out", 16'(pc_out), 16'h0004);
        ev(6'h20);
        step(1);
        chk("pc_out", 16'(pc_out), 16'h0004);
        step(14);
        chk("stack_overflow_flag", 16'(stack_overflow_flag), 16'h0000);
        step(1);
        chk("stack_overflow_flag", 16'(stack_overflow_flag), 16'h0001);
        chk("soft_reset", 16'(soft_reset), 16'h0001);
        ev(6'h00);
        do_reset();
        ev(6'h10);
        step(1);
        ev(6'h00);
        chk("stack_underflow_flag", 16'(stack_underflow_flag), 16'h0001);
        acc(1'b1, 1'b0, 1'b0, 7'h08, 8'h1f);
        acc(1'b0, 1'b0, 1'b0, 7'h20, 8'h00);
        chk("data_addr", 16'(data_addr), 16'h0fa0);
        chk("data_rd", 16'(data_rd), 16'h0001);
        chk("bank_select", 16'(bank_select), 16'h001f);
        acc(1'b1, 1'b0, 1'b0, 7'h09, 8'ha5);
        acc(1'b1, 1'b0, 1'b0, 7'h06, 8'h23);
        chk("accumulator", 16'(accumulator), 16'h00a5);
        acc(1'b1, 1'b0, 1'b0, 7'h07, 8'h01);
        acc(1'b1, 1'b0, 1'b0, 7'h04, 8'h85);
        acc(1'b1, 1'b0, 1'b0, 7'h05, 8'hff);
        acc(1'b0, 1'b1, 1'b1, 7'h00, 8'h00);
        chk("data_addr", 16'(data_addr), 16'h0123);
        acc(1'b0, 1'b1, 1'b0, 7'h00, 8'h00);
        idle();
        chk("pfm_rd", 16'(pfm_rd), 16'h0001);
        chk("stall", 16'(stall), 16'h0001);
        chk("pfm_addr", 16'(pfm_addr), 16'h0f85);
        chk("pfm_high_endurance", 16'(pfm_high_endurance), 16'h0001);
        {pfm_rvalid, pfm_rdata} = {1'b1, 14'h3a5c};
        step(1);
        pfm_rvalid = 1'b0;
        chk("file_rdata", 16'(file_rdata), 16'h005c);
        chk("file_rdata_valid", 16'(file_rdata_valid), 16'h0001);
        chk("accumulator", 16'(accumulator), 16'h005c);
        step(2);
        acc(1'b1, 1'b1, 1'b0, 7'h00, 8'h77);
        idle();
        chk("data_wr", 16'(data_wr), 16'h0000);
        ev(6'h01);
        step(1);
        ev(6'h00);
        chk("arith_flags", 16'(arith_flags), 16'h0008);
        acc(1'b1, 1'b0, 1'b0, 7'h03, 8'hff);
        chk("arith_flags", 16'(arith_flags), 16'h000f);
        acc(1'b1, 1'b0, 1'b0, 7'h03, 8'h00);
        file_clear = 1'b1;
        step(1);
        idle();
        step(1);
        chk("arith_flags", 16'(arith_flags), 16'h000c);
        alu(1'b1, 8'h05, 8'h05);
        step(1);
        chk("arith_flags", 16'(arith_flags), 16'h000f);
        alu(1'b0, 8'h0f, 8'h01);
        step(1);
        chk("arith_flags", 16'(arith_flags), 16'h000a);
        alu(1'b0, 8'hff, 8'h01);
        acc(1'b1, 1'b0, 1'b0, 7'h03, 8'h00);
        chk("arith_flags", 16'(arith_flags), 16'h000f);
        alu_flags_valid = 1'b0;
        idle();
        step(2);
        acc(1'b0, 1'b0, 1'b0, 7'h09, 8'h00);
        chk("file_rdata", 16'(file_rdata), 16'h005c);
        chk("data_rd", 16'(data_rd), 16'h0000);
        acc(1'b0, 1'b0, 1'b0, 7'h00, 8'h00);
        chk("file_rdata", 16'(file_rdata), 16'h0000);
        acc(1'b1, 1'b0, 1'b0, 7'h25, 8'h3c);
        idle();
        chk("data_wdata", 16'(data_wdata), 16'h003c);
        chk("data_wr", 16'(data_wr), 16'h0001);
        chk("data_addr", 16'(data_addr), 16'h0fa5);
        ev(6'h04);
        step(1);
        ev(6'h08);
        step(1);
        ev(6'h00);
        acc(1'b1, 1'b0, 1'b0, 7'h09, 8'h11);
        idle();
        irq_return = 1'b1;
        step(1);
        irq_return = 1'b0;
        chk("accumulator", 16'(accumulator), 16'h005c);
        chk("pc_out", 16'(pc_out), 16'h0ffe);
        sleep_exec = 1'b1;
        step(1);
        sleep_exec = 1'b0;
        chk("arith_flags", 16'(arith_flags), 16'h0007);
        wdt_clear = 1'b1;
        step(1);
        wdt_clear = 1'b0;
        chk("arith_flags", 16'(arith_flags), 16'h001f);
        step(2);
        give_verdict();
    end
endmodule : cmo_core_mem_tb
